// File: adcsi_pkg.sv
// Functional notes
// - data out changes on serial clock falls
// - internal serial clock is conversion clock / 8
// - clock source chosen at power-up and chip-select fall
// - clock pin high picks internal, low external
// - result leaves most significant bit first
// - data out released while chip select high
// - pending flag on data out outside readout
// - sleep entered when conversion finishes
// - first clock rise with select low starts readout
// - result held in static shift register
// - host captures on rising edges, 32 bits
// - 32nd falling edge starts next conversion (32nd rise with internal clock)
// - chip select rise during readout aborts, converts
// - host shortens readout before 32nd fall; adcsi_host always reads all 32 bits and raises select only after the 32nd fall
// - select held low gives continuous conversion
// - host holds clock low through power-on reset
// - result loaded when pending flag falls
// - word: flag, zero, sign, 29 result bits
package adcsi_pkg;
	localparam int unsigned ADCSI_CLK_HZ      = 25_000_000;
	localparam int unsigned ADCSI_CLK_NS      = 40;
	// internal conversion clock, a plain nominal figure
	localparam int unsigned ADCSI_CONV_HZ     = 1_250_000;
	localparam int unsigned ADCSI_SCK_DIV     = 8;
	localparam int unsigned ADCSI_INT_HALF    = ADCSI_CLK_HZ / ADCSI_CONV_HZ * ADCSI_SCK_DIV / 2;
	localparam int unsigned ADCSI_POR_NS      = 500_000;
	localparam int unsigned ADCSI_POR_CYC     = ADCSI_POR_NS / ADCSI_CLK_NS;
	// host serial clock half period, long enough to cover device sampling lag
	localparam int unsigned ADCSI_HOST_HALF   = 8;
	localparam int unsigned ADCSI_WORD_BITS   = 32;
	localparam int unsigned ADCSI_RESULT_BITS = 30;
	localparam int unsigned ADCSI_FLAG_POS    = 31;
	localparam int unsigned ADCSI_DUMMY_POS   = 30;
	localparam int unsigned ADCSI_SIGN_POS    = 29;
	localparam logic [31:0] ADCSI_BUSY_WORD   = 32'h8000_0000;
	typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_OUTPUT} adcsi_state_t;
	typedef enum logic [2:0] {H_POR, H_IDLE, H_CHECK, H_LOW, H_HIGH, H_DONE} adcsi_host_t;
endpackage

// File: adcsi_link_if.sv
`timescale 1ns/1ps
interface adcsi_link_if;
	logic cs_n;
	logic sck_host_o;
	logic sck_host_oe;
	logic sck_dev_o;
	logic sck_dev_oe;
	logic sdo_o;
	logic sdo_oe;
	wire  sck;
	wire  sdo;
	// weak pull-up on both shared lines when nobody drives
	assign sck = sck_host_oe ? sck_host_o : (sck_dev_oe ? sck_dev_o : 1'b1);
	assign sdo = sdo_oe ? sdo_o : 1'b1;
	modport dev (input cs_n, input sck, output sck_dev_o, output sck_dev_oe,
		output sdo_o, output sdo_oe);
	modport host (output cs_n, output sck_host_o, output sck_host_oe, input sck, input sdo);
endinterface

// File: adcsi_device.sv
`timescale 1ns/1ps
module adcsi_device import adcsi_pkg::*; #(
	parameter int unsigned POR_CYC = ADCSI_POR_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	adcsi_link_if.dev        link,
	output logic             conv_start,
	output logic             conv_busy,
	input  wire logic        conv_done,
	input  wire logic [29:0] conv_data,
	output logic             ext_mode
);
	// pin synchronisers and their edge detects
	logic         cs_m_q;
	logic         cs_s_q;
	logic         cs_p_q;
	logic         sck_m_q;
	logic         sck_s_q;
	logic         sck_p_q;
	logic         cs_fall;
	logic         cs_rise;
	logic         sck_rise;
	logic         sck_fall;

	// power-on window and clock source
	logic [15:0]  por_cnt_q;
	logic         por_done_q;
	logic         por_fin;
	logic         ext_mode_q;

	// internal serial clock generator
	logic [7:0]   div_q;
	logic         sck_int_q;
	logic         run_int;
	logic         tick;
	logic         int_rise;
	logic         int_fall;

	// readout sequencing and result shifter
	logic         rise_ev;
	logic         fall_ev;
	logic         last_fall;
	logic         enter_conv;
	logic [5:0]   bit_cnt_q;
	logic [31:0]  sreg_q;
	logic         start_q;
	adcsi_state_t state_q;
	adcsi_state_t state_d;

	// two-stage synchronisers, edges only from the settled stages
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cs_m_q  <= 1'b1;
			cs_s_q  <= 1'b1;
			cs_p_q  <= 1'b1;
			sck_m_q <= 1'b1;
			sck_s_q <= 1'b1;
			sck_p_q <= 1'b1;
		end else begin
			cs_m_q  <= link.cs_n;
			cs_s_q  <= cs_m_q;
			cs_p_q  <= cs_s_q;
			sck_m_q <= link.sck;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
		end
	end

	// edges only from settled stages, the raw pin is never decoded
	assign cs_fall  = cs_p_q & ~cs_s_q;
	assign cs_rise  = ~cs_p_q & cs_s_q;
	assign sck_rise = ~sck_p_q & sck_s_q;
	assign sck_fall = sck_p_q & ~sck_s_q;

	// power-on window, stretched so a slow host can settle the clock pin
	assign por_fin = !por_done_q && (por_cnt_q == 16'(POR_CYC - 1));
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			por_cnt_q  <= 16'h0000;
			por_done_q <= 1'b0;
		end else if (!por_done_q) begin
			por_cnt_q  <= por_cnt_q + 16'h0001;
			por_done_q <= por_fin;
		end
	end

	// clock source pick; the line idles high through the pull-up
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ext_mode_q <= 1'b0;
		end else if (por_fin || (por_done_q && cs_fall)) begin
			ext_mode_q <= ~sck_s_q;
		end
	end

	// internal serial clock: half period of four conversion clocks
	assign run_int  = !ext_mode_q && !cs_s_q && (state_q != ST_CONVERT);
	assign tick     = run_int && (div_q == 8'(ADCSI_INT_HALF - 1));
	assign int_rise = tick && !sck_int_q;
	assign int_fall = tick && sck_int_q && (state_q == ST_OUTPUT);
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			div_q     <= 8'h00;
			sck_int_q <= 1'b1;
		end else if (!run_int) begin
			div_q     <= 8'h00;
			sck_int_q <= 1'b1;
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			if (state_q == ST_SLEEP) begin
				sck_int_q <= tick; // held low, first rise opens readout
			end else if (tick) begin
				sck_int_q <= ~sck_int_q;
			end
		end
	end

	// clock edges that count, taken from whichever source is selected
	// limitation: with an external low half period under four system clocks the host samples data out before it shifts
	assign rise_ev   = ext_mode_q ? (sck_rise && !cs_s_q) : int_rise;
	assign fall_ev   = ext_mode_q ? (sck_fall && !cs_s_q) : int_fall;
	assign last_fall = ext_mode_q && fall_ev && (bit_cnt_q == 6'(ADCSI_WORD_BITS));

	// conversion state sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_CONVERT: begin
				if (conv_done && por_done_q) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (rise_ev) begin
					state_d = ST_OUTPUT;
				end
			end
			ST_OUTPUT: begin
				if (cs_rise) begin
					state_d = ST_CONVERT;
				end else if (last_fall) begin
					state_d = ST_CONVERT;
				end else if (!ext_mode_q && rise_ev
						&& bit_cnt_q == 6'(ADCSI_WORD_BITS - 1)) begin
					state_d = ST_CONVERT;
				end
			end
		endcase
	end

	// held-low select simply cycles convert, sleep, output again
	assign enter_conv = por_fin || (state_q == ST_OUTPUT && state_d == ST_CONVERT);

	// state register
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q <= ST_CONVERT;
		end else begin
			state_q <= state_d;
		end
	end

	// start request to the analog core, registered for a clean one-cycle pulse
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			start_q <= 1'b0;
		end else begin
			start_q <= enter_conv;
		end
	end

	// rising edges counted; 32 of them make a whole word
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bit_cnt_q <= 6'h00;
		end else if (state_q != ST_OUTPUT) begin
			bit_cnt_q <= rise_ev ? 6'h01 : 6'h00;
		end else if (rise_ev) begin
			bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	// static shift register; its top bit is the data-out level
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sreg_q <= ADCSI_BUSY_WORD;
		end else if (enter_conv) begin
			sreg_q <= ADCSI_BUSY_WORD; // pending flag high
		end else if (state_q == ST_CONVERT && state_d == ST_SLEEP) begin
			sreg_q <= {1'b0, 1'b0, conv_data}; // flag low, dummy zero
		end else if (state_q == ST_OUTPUT && fall_ev) begin
			sreg_q <= {sreg_q[30:0], 1'b0};
		end
	end

	// flag before readout and result bits during it share one bit
	assign link.sdo_o      = sreg_q[ADCSI_FLAG_POS];
	// released while deselected so other converters can share the line
	assign link.sdo_oe     = !cs_s_q;

	// drive clock only in internal mode with select low after power-on
	assign link.sck_dev_o  = sck_int_q;
	assign link.sck_dev_oe = por_done_q && !ext_mode_q && !cs_s_q;

	// status towards the analog core and the system
	assign conv_start      = start_q;
	assign conv_busy       = (state_q == ST_CONVERT);
	assign ext_mode        = ext_mode_q;
endmodule

// File: adcsi_host.sv
`timescale 1ns/1ps
module adcsi_host import adcsi_pkg::*; #(
	parameter int unsigned POR_CYC = ADCSI_POR_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	adcsi_link_if.host       link,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [31:0]      out_data
);
	adcsi_host_t  state_q;
	logic [15:0]  cnt_q;
	logic [5:0]   bits_q;
	logic [31:0]  shift_q;
	logic         cs_n_q;
	logic         sck_q;
	logic [31:0]  mem_q [2];
	logic         wp_q, rp_q;
	logic [1:0]   fill_q;
	logic         push, pop, in_ready, half_done;

	assign half_done = (cnt_q == 16'(ADCSI_HOST_HALF - 1));
	assign push      = (state_q == H_DONE);
	assign pop       = out_valid && out_ready;
	assign in_ready  = (fill_q != 2'd2);

	// external-clock single-cycle reader; clock held low so device picks it
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q <= H_POR;
			cnt_q   <= 16'h0000;
			bits_q  <= 6'h00;
			shift_q <= 32'h0000_0000;
			cs_n_q  <= 1'b1;
			sck_q   <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			unique case (state_q)
				H_POR: begin
					if (cnt_q == 16'(POR_CYC + ADCSI_HOST_HALF)) begin
						state_q <= H_IDLE;
						cnt_q   <= 16'h0000;
					end
				end
				H_IDLE: begin
					// a full buffer stalls the next readout, no word lost
					if (!in_ready) begin
						cnt_q <= 16'h0000; // restart the wait, else half_done only after wrap
					end else if (half_done) begin
						cs_n_q  <= 1'b0; // clock low here picks external
						state_q <= H_CHECK;
						cnt_q   <= 16'h0000;
					end
				end
				H_CHECK: begin
					if (half_done) begin
						cnt_q <= 16'h0000;
						if (!link.sdo) begin
							state_q <= H_LOW;
							bits_q  <= 6'h00;
						end
					end
				end
				H_LOW: begin
					if (half_done) begin
						sck_q   <= 1'b1;
						shift_q <= {shift_q[30:0], link.sdo};
						bits_q  <= bits_q + 6'h01;
						state_q <= H_HIGH;
						cnt_q   <= 16'h0000;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						sck_q <= 1'b0;
						cnt_q <= 16'h0000;
						// the 32nd fall ends the word, select rises after it
						state_q <= (bits_q == 6'(ADCSI_WORD_BITS)) ? H_DONE : H_LOW;
					end
				end
				H_DONE: begin
					cs_n_q  <= 1'b1;
					state_q <= H_IDLE;
					cnt_q   <= 16'h0000;
				end
			endcase
		end
	end

	// two-entry result buffer
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wp_q   <= 1'b0;
			rp_q   <= 1'b0;
			fill_q <= 2'd0;
		end else begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			fill_q <= fill_q + 2'(push) - 2'(pop);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wp_q] <= shift_q;
		end
	end

	assign out_valid        = (fill_q != 2'd0);
	assign out_data         = mem_q[rp_q];
	assign link.cs_n        = cs_n_q;
	assign link.sck_host_o  = sck_q;
	assign link.sck_host_oe = 1'b1;
endmodule

// File: adcsi_assertions.sv
`timescale 1ns/1ps
module adcsi_assertions (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sck_dev_oe,
	input wire logic conv_start,
	input wire logic conv_busy,
	input wire logic ext_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic       sck_q;
	logic [7:0] rise_q;
	// rises seen while selected since the last start
	always_ff @(posedge ref_clk) begin
		sck_q <= sck;
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn || conv_start) begin
			rise_q <= 8'h00;
		end else if (sck && !sck_q && !cs_n) begin
			rise_q <= rise_q + 8'h01;
		end
	end
	a_sdo_release: assert property (cs_n [*3] |-> !sdo_oe)
		else $error("data out driven while deselected");
	a_cs_sync: assert property ($fell(cs_n) |-> !sdo_oe ##1 !sdo_oe ##[1:2] sdo_oe)
		else $error("select sampling lag wrong");
	a_shift_on_fall: assert property ($rose(sck) && ext_mode |=> $stable(sdo_o) [*3])
		else $error("data out moved after a rise");
	a_busy_flag: assert property (conv_busy && $past(conv_busy) && sdo_oe |-> sdo_o)
		else $error("flag low while converting");
	a_sleep_flag: assert property ($fell(conv_busy) |-> !sdo_o)
		else $error("flag not low on sleep");
	a_start_busy: assert property (conv_start |-> ##[0:2] conv_busy)
		else $error("no conversion after start");
	a_word_count: assert property (conv_start && rise_q != 8'h00 |-> rise_q == 8'h20)
		else $error("readout length not 32");
	a_ext_select: assert property ($fell(cs_n) && !sck |-> ##[1:4] ext_mode)
		else $error("low clock pin not external");
	a_sck_owner: assert property (ext_mode |-> !sck_dev_oe)
		else $error("device drives clock in external mode");
	c_full_read: cover property (conv_start && rise_q == 8'h20);
	c_sleep_sel: cover property ($fell(conv_busy) && !cs_n);
	c_ext_mode: cover property ($rose(ext_mode));
endmodule

// File: test_adc_serial_result_interface.sv
`timescale 1ns/1ps
module test_adc_serial_result_interface;
	import adcsi_pkg::*;
	localparam int N = 12;
	logic        ref_clk, rstn, conv_start, conv_busy, conv_done, ext_mode;
	logic        out_valid, out_ready, stall;
	logic [29:0] conv_data, w;
	logic [31:0] out_data;
	logic [15:0] rnd = 16'd22590;
	logic [29:0] pat [3] = '{30'h3fff_ffff, 30'h2000_0000, 30'h0000_0000};
	logic [31:0] exp_q [$];
	int          n_mismatch, checks, sent, got, dly, i;
	adcsi_link_if link();
	adcsi_device #(.POR_CYC(20)) adcsi_device_inst (.ref_clk(ref_clk), .rstn(rstn),
		.link(link), .conv_start(conv_start), .conv_busy(conv_busy), .conv_done(conv_done),
		.conv_data(conv_data), .ext_mode(ext_mode));
	adcsi_host #(.POR_CYC(20)) adcsi_host_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
	adcsi_assertions adcsi_assertions_inst (.ref_clk(ref_clk), .rstn(rstn), .cs_n(link.cs_n),
		.sck(link.sck), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
		.sck_dev_oe(link.sck_dev_oe), .conv_start(conv_start), .conv_busy(conv_busy),
		.ext_mode(ext_mode));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// analog core stand-in: one result per start, boundary words first
	always @(posedge ref_clk) begin
		rnd = lfsr(rnd);
		out_ready <= !stall && (rnd[0] || rnd[1]);
		if (!rstn) begin
			dly = 0;
			conv_data <= 30'h0000_0000;
		end else if (conv_start && sent < N) begin
			dly = 16 + int'(rnd[5:0]);
		end else if (dly > 0) begin
			dly--;
		end
		if (rstn && dly == 1) begin
			w = (sent < 3) ? pat[sent] : {rnd[13:0], lfsr(rnd)};
			exp_q.push_back({2'b00, w});
			sent++;
			conv_data <= w;
		end
		conv_done <= rstn && dly == 1;
	end
	// results compared in arrival order
	always @(posedge ref_clk) begin
		if (rstn && out_valid === 1'b1 && out_ready) begin
			check(out_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
			got++;
		end
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end
	initial begin
		rstn  = 1'b0;
		stall = 1'b1;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		// hold the reader off so the buffer fills and a result waits in sleep
		for (i = 0; i < 5000 && sent < 3; i++) @(posedge ref_clk);
		repeat (600) @(posedge ref_clk);
		stall <= 1'b0;
		for (i = 0; i < 30000 && got < N; i++) @(posedge ref_clk);
		check(32'(got), 32'(N));
		check({31'h0, ext_mode}, 32'h0000_0001);
		test_done();
	end
endmodule
